//--- shared/iathr_pkg.sv
// Package with the register map, field layout and reset values of the input alarm threshold bank.
package iathr_pkg;
  // Register byte offsets; each register spans four byte addresses.
  localparam logic [7:0] IATHR_UPPER_ADDR = 8'h24;
  localparam logic [7:0] IATHR_LOWER_ADDR = 8'h28;
  localparam logic [7:0] IATHR_ALARM_ADDR = 8'h20;
  // Field positions.
  localparam int IATHR_HYST_MSB = 31;
  localparam int IATHR_HYST_LSB = 24;
  localparam int IATHR_HYST_NIB_LSB = 28;
  localparam int IATHR_LIMIT_MSB = 15;
  localparam int IATHR_CMP_LSB = 2;
  localparam int IATHR_RESULT_W = 14;
  // Alarm flag register bit positions.
  localparam int IATHR_OVW_BIT = 0;
  localparam int IATHR_TRIP_HIGH_BIT = 4;
  localparam int IATHR_TRIP_LOW_BIT = 5;
  localparam int IATHR_ACT_HIGH_BIT = 10;
  localparam int IATHR_ACT_LOW_BIT = 11;
  // Reset values.
  localparam logic [7:0] IATHR_HYST_RST = 8'h00;
  localparam logic [15:0] IATHR_UPPER_RST = 16'hffff;
  localparam logic [15:0] IATHR_LOWER_RST = 16'h0000;
endpackage

//--- hw/iathr_regs.sv
// Input alarm threshold registers with hysteresis comparators and alarm flags.
// Overview of the bank.
// The bank holds three 32-bit words that software reaches through byte
// addresses. Only the word base address of each register is decoded; a
// whole word is written or read in one access, never a single byte.
// The upper word carries the hysteresis byte in its top byte, a
// reserved byte that reads zero, and the 16-bit upper limit below.
// The lower word carries the 16-bit lower limit; its top half reads zero.
//
// How the comparison works.
// Both limits take part in the comparison through bits 15 down to 2,
// which gives a 14-bit threshold in the units of a conversion result.
// The hysteresis is the upper nibble of the hysteresis byte, also in
// result units. All arithmetic is done one bit wider than the result,
// so that the lower release point can never wrap past the top code.
// The upper release point saturates at zero for the same reason.
//
// How the flags behave.
// An active flag follows its comparator with hysteresis and drops as
// soon as the result passes back through the release point.
// A tripped flag is sticky: it is set together with its active flag and
// only the clear input takes it down again. When a clear meets a flag
// that is still active, the flag wins and stays set.
// The overall flag is the OR of the tripped flags.
//
// Timing seen by software.
// Read data stand for one cycle after the read strobe and are zero
// otherwise. The clock enable freezes every register, read data too.
// Software must keep the low bits of each field at zero; the logic
// stores them as written but never uses them in a comparison.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
module iathr_regs (
  // Clock, reset and clock enable.
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // Register bus.
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [31:0] rd_data,
  // Conversion results in, alarm flags out.
  input wire logic result_valid,
  input wire logic [13:0] result,
  input wire logic trip_clear,
  output logic alarm_high,
  output logic alarm_low,
  output logic overall_alarm_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [7:0] input_alarm_hysteresis_reg;
  logic [7:0] input_alarm_hysteresis_next;
  logic [15:0] input_alarm_upper_limit_reg;
  logic [15:0] input_alarm_upper_limit_next;
  logic [15:0] input_alarm_lower_limit_reg;
  logic [15:0] input_alarm_lower_limit_next;

  // Registered read data.
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;

  // Active flags, which follow the comparators.
  logic act_high_reg;
  logic act_high_next;
  logic act_low_reg;
  logic act_low_next;

  // Tripped flags, which stay set until cleared.
  logic trp_high_reg;
  logic trp_high_next;
  logic trp_low_reg;
  logic trp_low_next;

  // Comparison operands and release points, one bit wider than a result.
  logic [14:0] upper_cmp;
  logic [14:0] lower_cmp;
  logic [14:0] hyst_ext;
  logic [14:0] res_ext;
  logic [14:0] high_release;
  logic [14:0] low_release;

  // Read views of the three decoded words.
  logic [31:0] upper_word;
  logic [31:0] lower_word;
  logic [31:0] alarm_word;

  // Comparison operands: limits use bits 15-2, widened by one bit for hysteresis arithmetic.
  always_comb begin
    upper_cmp = {1'b0, input_alarm_upper_limit_reg[iathr_pkg::IATHR_LIMIT_MSB:iathr_pkg::IATHR_CMP_LSB]};
    lower_cmp = {1'b0, input_alarm_lower_limit_reg[iathr_pkg::IATHR_LIMIT_MSB:iathr_pkg::IATHR_CMP_LSB]};
    hyst_ext = {11'h000, input_alarm_hysteresis_reg[iathr_pkg::IATHR_HYST_MSB - iathr_pkg::IATHR_HYST_LSB:
      iathr_pkg::IATHR_HYST_NIB_LSB - iathr_pkg::IATHR_HYST_LSB]};
    res_ext = {1'b0, result};
    // The high release point saturates at zero and the low one is one bit wider, so a large hysteresis never wraps.
    high_release = (upper_cmp > hyst_ext) ? (upper_cmp - hyst_ext) : 15'h0000;
    low_release = lower_cmp + hyst_ext;
  end

  // Read views of the registers; reserved bits read as zero.
  always_comb begin
    upper_word = {input_alarm_hysteresis_reg, 8'h00, input_alarm_upper_limit_reg};
    lower_word = {16'h0000, input_alarm_lower_limit_reg};
    alarm_word = 32'h0000_0000;
    alarm_word[iathr_pkg::IATHR_ACT_HIGH_BIT] = act_high_reg;
    alarm_word[iathr_pkg::IATHR_ACT_LOW_BIT] = act_low_reg;
    alarm_word[iathr_pkg::IATHR_TRIP_HIGH_BIT] = trp_high_reg;
    alarm_word[iathr_pkg::IATHR_TRIP_LOW_BIT] = trp_low_reg;
    alarm_word[iathr_pkg::IATHR_OVW_BIT] = trp_high_reg | trp_low_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for registers, read data and alarms.
  always_comb begin
    input_alarm_hysteresis_next = input_alarm_hysteresis_reg;
    input_alarm_upper_limit_next = input_alarm_upper_limit_reg;
    input_alarm_lower_limit_next = input_alarm_lower_limit_reg;
    rd_data_next = 32'h0000_0000;
    act_high_next = act_high_reg;
    act_low_next = act_low_reg;
    trp_high_next = trp_high_reg;
    trp_low_next = trp_low_reg;

    // Writes land on the word base address only; reserved bits are not stored.
    if (wr_strobe) begin
      if (addr == iathr_pkg::IATHR_UPPER_ADDR) begin
        input_alarm_hysteresis_next = wr_data[iathr_pkg::IATHR_HYST_MSB:iathr_pkg::IATHR_HYST_LSB];
        input_alarm_upper_limit_next = wr_data[iathr_pkg::IATHR_LIMIT_MSB:0];
      end else if (addr == iathr_pkg::IATHR_LOWER_ADDR) begin
        input_alarm_lower_limit_next = wr_data[iathr_pkg::IATHR_LIMIT_MSB:0];
      end
    end

    // Unmapped addresses read as zero.
    if (rd_strobe) begin
      unique case (addr)
        iathr_pkg::IATHR_UPPER_ADDR: rd_data_next = upper_word;
        iathr_pkg::IATHR_LOWER_ADDR: rd_data_next = lower_word;
        iathr_pkg::IATHR_ALARM_ADDR: rd_data_next = alarm_word;
        default: rd_data_next = 32'h0000_0000;
      endcase
    end

    // Active flags follow the hysteresis comparators on each new result.
    // Between two results they hold, so a flag never chatters on idle cycles.
    if (result_valid) begin
      if (res_ext > upper_cmp) begin
        act_high_next = 1'b1;
      end else if (res_ext < high_release) begin
        act_high_next = 1'b0;
      end
      if (res_ext < lower_cmp) begin
        act_low_next = 1'b1;
      end else if (res_ext > low_release) begin
        act_low_next = 1'b0;
      end
    end

    // Tripped flags are sticky; a new trip wins over a clear in the same cycle.
    // The set reads the next active value so that both flags rise together.
    if (trip_clear) begin
      trp_high_next = 1'b0;
      trp_low_next = 1'b0;
    end
    if (act_high_next) begin
      trp_high_next = 1'b1;
    end
    if (act_low_next) begin
      trp_low_next = 1'b1;
    end
  end

  // State registers, frozen while the clock enable is low.
  // Reset is synchronous and wins over the clock enable, so a held reset
  // always brings the bank to its documented values.
  always_ff @(posedge clock) begin
    if (rst) begin
      input_alarm_hysteresis_reg <= iathr_pkg::IATHR_HYST_RST;
      input_alarm_upper_limit_reg <= iathr_pkg::IATHR_UPPER_RST;
      input_alarm_lower_limit_reg <= iathr_pkg::IATHR_LOWER_RST;
      rd_data_reg <= 32'h0000_0000;
      act_high_reg <= 1'b0;
      act_low_reg <= 1'b0;
      trp_high_reg <= 1'b0;
      trp_low_reg <= 1'b0;
    end else if (clk_en) begin
      input_alarm_hysteresis_reg <= input_alarm_hysteresis_next;
      input_alarm_upper_limit_reg <= input_alarm_upper_limit_next;
      input_alarm_lower_limit_reg <= input_alarm_lower_limit_next;
      rd_data_reg <= rd_data_next;
      act_high_reg <= act_high_next;
      act_low_reg <= act_low_next;
      trp_high_reg <= trp_high_next;
      trp_low_reg <= trp_low_next;
    end
  end

  // Outputs straight from flip-flops.
  // The overall flag is an OR of the two tripped flip-flops, not a flip-flop of its own.
  assign rd_data = rd_data_reg;
  assign alarm_high = act_high_reg;
  assign alarm_low = act_low_reg;
  assign overall_alarm_flag = trp_high_reg | trp_low_reg;

endmodule // iathr_regs

//--- verif/iathr_chk.sv
// Checker for the input alarm threshold registers.
`timescale 1ns/10ps
module iathr_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic result_valid,
  input wire logic trip_clear,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic [31:0] rd_data,
  input wire logic [13:0] result,
  input wire logic alarm_high,
  input wire logic alarm_low,
  input wire logic overall_alarm_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [31:0] up_q, lo_q;
  logic rd, rv;
  assign rd = rd_strobe && clk_en;
  assign rv = result_valid && clk_en;
  // Shadow copies of the writable fields, with read-only bits masked.
  always_ff @(posedge clock) begin
    if (rst) begin
      up_q <= 32'h0000ffff;
      lo_q <= 32'h0;
    end else if (clk_en && wr_strobe && addr == 8'h24) up_q <= wr_data & 32'hff00ffff;
    else if (clk_en && wr_strobe && addr == 8'h28) lo_q <= wr_data & 32'h0000ffff;
  end
  a_upper_read: assert property (rd && addr == 8'h24 |=> rd_data == up_q)
    else $error("Upper register readback wrong.");
  a_lower_read: assert property (rd && addr == 8'h28 |=> rd_data == lo_q)
    else $error("Lower register readback wrong.");
  a_unmapped_zero: assert property (rd && !(addr inside {8'h20, 8'h24, 8'h28}) |=> rd_data == 32'h0)
    else $error("Unmapped read not zero.");
  a_overall_or: assert property (alarm_high || alarm_low |-> overall_alarm_flag)
    else $error("Overall flag missing.");
  a_high_set: assert property (rv && result > up_q[15:2] |=> alarm_high)
    else $error("High alarm not raised.");
  a_high_hold: assert property (alarm_high && clk_en && !(rv && 15'(result) + up_q[31:28] < up_q[15:2])
    |=> alarm_high)
    else $error("High alarm dropped early.");
  a_high_release: assert property (rv && 15'(result) + up_q[31:28] < up_q[15:2] |=> !alarm_high)
    else $error("High alarm not released.");
  a_low_set: assert property (rv && result < lo_q[15:2] |=> alarm_low)
    else $error("Low alarm not raised.");
  a_low_hold: assert property (alarm_low && clk_en && !(rv && result > 15'(lo_q[15:2]) + up_q[31:28])
    |=> alarm_low)
    else $error("Low alarm dropped early.");
  a_low_release: assert property (rv && result > 15'(lo_q[15:2]) + up_q[31:28] |=> !alarm_low)
    else $error("Low alarm not released.");
  a_rd_idle_zero: assert property (clk_en && !rd_strobe |=> rd_data == 32'h0)
    else $error("Read data not zero when idle.");
  cover property (rd && addr == 8'h24);
  cover property (alarm_high ##1 !alarm_high);
  cover property (alarm_low ##1 !alarm_low);
endmodule // iathr_chk
bind iathr_regs iathr_chk i_iathr_chk (.clock(clock), .rst(rst), .clk_en(clk_en), .wr_strobe(wr_strobe),
  .rd_strobe(rd_strobe), .result_valid(result_valid), .trip_clear(trip_clear), .addr(addr), .wr_data(wr_data),
  .rd_data(rd_data), .result(result), .alarm_high(alarm_high), .alarm_low(alarm_low),
  .overall_alarm_flag(overall_alarm_flag));

//--- verif/testbench.sv
// Self-checking testbench for the input alarm threshold registers.
`timescale 1ns/10ps
module testbench;
  logic clock = 0, rst = 1, wr_strobe = 0, rd_strobe = 0, result_valid = 0, trip_clear = 0;
  logic clk_en = 1;
  logic [7:0] addr = 8'h0;
  logic [31:0] wr_data = 32'h0, rd_data;
  logic [13:0] result = 14'h0;
  logic alarm_high, alarm_low, overall_alarm_flag;
  int mismatches = 0, tests_run = 0;
  always #2 clock = ~clock;
  iathr_regs i_iathr_regs (.clock(clock), .rst(rst), .clk_en(clk_en), .addr(addr), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .result_valid(result_valid),
    .result(result), .trip_clear(trip_clear), .alarm_high(alarm_high), .alarm_low(alarm_low),
    .overall_alarm_flag(overall_alarm_flag));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t value mismatch", $time);
    end
  endtask
  task automatic results();
    if (mismatches == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One bus cycle; a read compares the word that stands in the following cycle.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_strobe <= w;
    rd_strobe <= !w;
    @(posedge clock);
    wr_strobe <= 1'b0;
    rd_strobe <= 1'b0;
    #1;
    if (!w) chk(rd_data, d);
  endtask
  // One conversion result, then the high, low and overall flags are compared.
  task automatic res(input logic [13:0] v, input logic [2:0] e);
    result <= v;
    result_valid <= 1'b1;
    @(posedge clock);
    result_valid <= 1'b0;
    #1;
    chk({alarm_high, alarm_low, overall_alarm_flag}, e);
  endtask
  // Main sequence: limits 40h and 20h in result units, hysteresis 3.
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    #1;
    acc(0, 8'h24, 32'h0000ffff);
    acc(0, 8'h28, 32'h0);
    acc(0, 8'h2c, 32'h0);
    acc(1, 8'h24, 32'h30ff0100);
    acc(1, 8'h28, 32'hffff0080);
    acc(0, 8'h24, 32'h30000100);
    acc(0, 8'h28, 32'h00000080);
    // A write while the clock enable is low must not land.
    clk_en <= 1'b0;
    acc(1, 8'h24, 32'h0000fffc);
    clk_en <= 1'b1;
    acc(0, 8'h24, 32'h30000100);
    res(14'h0040, 3'b000);
    res(14'h0041, 3'b101);
    res(14'h003d, 3'b101);
    res(14'h003c, 3'b001);
    res(14'h001f, 3'b011);
    res(14'h0023, 3'b011);
    res(14'h0024, 3'b001);
    acc(0, 8'h20, 32'h00000031);
    // A clear that meets a new trip loses.
    trip_clear <= 1'b1;
    res(14'h0041, 3'b101);
    trip_clear <= 1'b0;
    res(14'h003c, 3'b001);
    trip_clear <= 1'b1;
    @(posedge clock);
    trip_clear <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk(overall_alarm_flag, 1'b0);
    acc(0, 8'h20, 32'h00000000);
    results();
  end
  // Watchdog against a hang.
  initial begin
    #20000;
    mismatches++;
    results();
  end
endmodule // testbench
